// file: core/tpg_three_phase_pwm.sv
// three-phase centre-based pwm generator with register port
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
module tpg_three_phase_pwm
    import tpg_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic TRIP_N,
    input wire logic SYNC_IN,
    output logic SYNC_OUT,
    output logic SYNC_OE,
    output logic PAIR0_HIGH_OUT,
    output logic PAIR0_LOW_OUT,
    output logic PAIR1_HIGH_OUT,
    output logic PAIR1_LOW_OUT,
    output logic PAIR2_HIGH_OUT,
    output logic PAIR2_LOW_OUT,
    output logic SYNC_IRQ,
    output logic TRIP_IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // software registers

    logic [15:0] half_period_count_reg;
    logic [9:0] dead_time_reg;
    logic [9:0] sync_width_reg;
    logic [15:0] duty_reg [3];
    logic [8:0] output_enable_reg;
    logic [9:0] gate_chop_config_reg;
    logic [3:0] mode_control_reg;
    logic [1:0] generator_status_reg;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            half_period_count_reg <= TPG_PERIOD_RST;
            dead_time_reg <= TPG_DEAD_RST;
            sync_width_reg <= TPG_SYNCW_RST;
            duty_reg[0] <= TPG_DUTY_RST;
            duty_reg[1] <= TPG_DUTY_RST;
            duty_reg[2] <= TPG_DUTY_RST;
            output_enable_reg <= TPG_OUTEN_RST;
            gate_chop_config_reg <= TPG_CHOP_RST;
            mode_control_reg <= TPG_MODE_RST;
        end
        else if (WR)
        begin
            if (hit(ADDR, TPG_OFS_PERIOD))
                half_period_count_reg <= WDATA[15:0]; // RL2 RL21
            if (hit(ADDR, TPG_OFS_DEAD))
                dead_time_reg <= WDATA[9:0]; // RL2 RL22
            if (hit(ADDR, TPG_OFS_SYNCW))
                sync_width_reg <= WDATA[9:0];
            if (hit(ADDR, TPG_OFS_DUTY0))
                duty_reg[0] <= WDATA[15:0]; // RL3
            if (hit(ADDR, TPG_OFS_DUTY1))
                duty_reg[1] <= WDATA[15:0]; // RL3
            if (hit(ADDR, TPG_OFS_DUTY2))
                duty_reg[2] <= WDATA[15:0]; // RL3
            if (hit(ADDR, TPG_OFS_OUTEN))
                output_enable_reg <= WDATA[8:0];
            if (hit(ADDR, TPG_OFS_CHOP))
                gate_chop_config_reg <= WDATA[9:0];
            if (hit(ADDR, TPG_OFS_MODE))
                mode_control_reg <= WDATA[3:0];
        end
    end

    // read data stand in the cycle after the strobe only
    always_ff @(posedge CORE_CLK)
    begin
        if (RST || !RD)
            RDATA <= 32'h0000_0000;
        else
        begin
            unique case (ADDR)
                TPG_OFS_PERIOD: RDATA <= {16'h0000, half_period_count_reg};
                TPG_OFS_DEAD: RDATA <= {22'h000000, dead_time_reg};
                TPG_OFS_SYNCW: RDATA <= {22'h000000, sync_width_reg};
                TPG_OFS_DUTY0: RDATA <= {16'h0000, duty_reg[0]};
                TPG_OFS_DUTY1: RDATA <= {16'h0000, duty_reg[1]};
                TPG_OFS_DUTY2: RDATA <= {16'h0000, duty_reg[2]};
                TPG_OFS_OUTEN: RDATA <= {23'h000000, output_enable_reg};
                TPG_OFS_CHOP: RDATA <= {22'h000000, gate_chop_config_reg};
                TPG_OFS_MODE: RDATA <= {28'h0000000, mode_control_reg};
                TPG_OFS_STATUS: RDATA <= {30'h00000000, generator_status_reg}; // RL17
                default: RDATA <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shutdown controller and external sync input

    logic mode_run;
    logic mode_ext;
    logic mode_dbl;
    logic mode_resync;
    logic trip_seen;
    logic timing_reset;
    logic sync_meta;
    logic sync_safe;
    logic sync_safe_d;
    logic sync_raw_d;
    logic ext_edge;

    assign mode_run = mode_control_reg[TPG_MODE_RUN_BIT];
    assign mode_ext = mode_control_reg[TPG_MODE_EXT_BIT];
    assign mode_dbl = mode_control_reg[TPG_MODE_DBL_BIT]; // RL10
    assign mode_resync = mode_control_reg[TPG_MODE_RESYNC_BIT];
    // timing unit restarts cleanly after a trip is released
    assign timing_reset = RST || !TRIP_N || !mode_run; // RL19

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            trip_seen <= 1'b0;
            TRIP_IRQ <= 1'b0;
        end
        else
        begin
            trip_seen <= !TRIP_N;
            TRIP_IRQ <= !TRIP_N && !trip_seen; // RL20
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            sync_meta <= 1'b0;
            sync_safe <= 1'b0;
            sync_safe_d <= 1'b0;
            sync_raw_d <= 1'b0;
        end
        else
        begin
            sync_meta <= SYNC_IN; // RL14
            sync_safe <= sync_meta;
            sync_safe_d <= sync_safe;
            sync_raw_d <= SYNC_IN;
        end
    end

    // resync adds two cycles of latency and one of jitter
    assign ext_edge = mode_ext && (mode_resync ? (sync_safe && !sync_safe_d)
                                               : (SYNC_IN && !sync_raw_d)); // RL13 RL14 RL15

    ////////////////////////////////////////////////////////////////////////////
    // up/down counter and sync instants

    tpg_half_t half;
    tpg_half_t next_half;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic period_start;
    logic mid_sync;
    logic sync_evt;
    logic [15:0] sh_period;
    logic [9:0] sh_dead;
    logic [15:0] sh_duty [3];
    logic [8:0] sh_outen;

    always_comb
    begin
        next_half = half;
        next_cnt = cnt;
        period_start = 1'b0;
        mid_sync = 1'b0;
        unique case (half)
            TPG_IDLE:
            begin
                if (!mode_ext || ext_edge)
                begin
                    next_half = TPG_FIRST;
                    next_cnt = 16'h0000;
                    period_start = 1'b1;
                end
            end
            TPG_FIRST:
            begin
                if (ext_edge)
                begin
                    next_cnt = 16'h0000;
                    period_start = 1'b1;
                end
                else if (cnt >= sh_period - 16'h0001) // RL21 RL25
                begin
                    next_half = TPG_SECOND;
                    mid_sync = mode_dbl; // RL9 RL11
                end
                else
                    next_cnt = cnt + 16'h0001;
            end
            TPG_SECOND:
            begin
                if (ext_edge || (cnt == 16'h0000 && !mode_ext))
                begin
                    next_half = TPG_FIRST;
                    next_cnt = 16'h0000;
                    period_start = 1'b1; // RL11
                end
                else if (cnt == 16'h0000)
                    next_half = TPG_IDLE;
                else
                    next_cnt = cnt - 16'h0001; // RL25
            end
            default:
                next_half = TPG_IDLE;
        endcase
    end

    assign sync_evt = period_start || mid_sync; // RL8 RL9

    always_ff @(posedge CORE_CLK)
    begin
        if (timing_reset)
        begin
            half <= TPG_IDLE;
            cnt <= 16'h0000;
        end
        else
        begin
            half <= next_half;
            cnt <= next_cnt;
        end
    end

    // values in use change only at sync instants
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            sh_period <= TPG_PERIOD_RST;
            sh_dead <= TPG_DEAD_RST;
            sh_duty[0] <= TPG_DUTY_RST;
            sh_duty[1] <= TPG_DUTY_RST;
            sh_duty[2] <= TPG_DUTY_RST;
            sh_outen <= TPG_OUTEN_RST;
        end
        else if (sync_evt && !timing_reset)
        begin
            sh_period <= half_period_count_reg; // RL23
            sh_dead <= dead_time_reg;
            sh_duty[0] <= duty_reg[0];
            sh_duty[1] <= duty_reg[1];
            sh_duty[2] <= duty_reg[2];
            sh_outen <= output_enable_reg; // RL23
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            generator_status_reg <= 2'b00;
        else
        begin
            generator_status_reg[TPG_STA_HALF_BIT] <= (half == TPG_SECOND); // RL24
            generator_status_reg[TPG_STA_TRIP_BIT] <= TRIP_N; // RL17
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sync pulse unit

    logic [9:0] sync_left;

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            sync_left <= 10'h000;
            SYNC_OUT <= 1'b0;
            SYNC_IRQ <= 1'b0;
        end
        else
        begin
            SYNC_IRQ <= sync_evt && !timing_reset; // RL20
            if (sync_evt && !timing_reset && !mode_ext)
            begin
                // width zero still gives a one-cycle pulse
                sync_left <= (sync_width_reg == 10'h000) ? 10'h000
                                                          : sync_width_reg - 10'h001;
                SYNC_OUT <= 1'b1; // RL12
            end
            else if (sync_left != 10'h000)
                sync_left <= sync_left - 10'h001;
            else
                SYNC_OUT <= 1'b0;
        end
    end

    assign SYNC_OE = !mode_ext; // RL12 RL13

    ////////////////////////////////////////////////////////////////////////////
    // gate chopping carrier

    logic [7:0] chop_div;
    logic chop_tick;
    logic chop_wave;

    assign chop_tick = (chop_div == gate_chop_config_reg[7:0]); // RL6

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            chop_div <= 8'h00;
            chop_wave <= 1'b0;
        end
        else if (chop_tick)
        begin
            chop_div <= 8'h00;
            chop_wave <= !chop_wave;
        end
        else
            chop_div <= chop_div + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-pair timing, crossover, enable, chopping, trip (all active low)

    logic [5:0] drive_n;
    logic [5:0] pin_n;

    generate
        for (genvar p = 0; p < 3; p++)
        begin : g_pair
            logic signed [18:0] th_hi;
            logic signed [18:0] th_lo;
            logic signed [18:0] cnt_s;
            logic run;
            logic hi_on;
            logic lo_on;
            logic route_hi;
            logic route_lo;
            logic gate_hi;
            logic gate_lo;
            assign cnt_s = {3'b000, cnt};
            // edges moved apart by dead time each, 2x dead total gap
            assign th_hi = {3'b000, sh_period} - {3'b000, sh_duty[p]}
                           + {9'h000, sh_dead}; // RL22
            assign th_lo = {3'b000, sh_period} - {3'b000, sh_duty[p]}
                           - {9'h000, sh_dead}; // RL22
            assign run = (half != TPG_IDLE);
            assign hi_on = run && (cnt_s >= th_hi); // RL18 RL25
            assign lo_on = run && (cnt_s < th_lo); // RL18 RL25
            assign route_hi = sh_outen[TPG_XOVER_LSB + p] ? lo_on : hi_on; // RL5
            assign route_lo = sh_outen[TPG_XOVER_LSB + p] ? hi_on : lo_on; // RL5
            assign gate_hi = route_hi && sh_outen[TPG_EN_LSB + 2 * p]; // RL4
            assign gate_lo = route_lo && sh_outen[TPG_EN_LSB + 2 * p + 1]; // RL4
            // chopping only ever shortens on-time, never adds a pulse
            always_ff @(posedge CORE_CLK)
            begin
                if (timing_reset)
                    drive_n[2 * p +: 2] <= 2'b11;
                else
                begin
                    drive_n[2 * p] <= !(gate_hi && (chop_wave
                        || !gate_chop_config_reg[TPG_CHOP_HI_BIT])); // RL6 RL7
                    drive_n[2 * p + 1] <= !(gate_lo && (chop_wave
                        || !gate_chop_config_reg[TPG_CHOP_LO_BIT])); // RL6 RL7
                end
            end
            // trip override wins with no clocked stage in the path
            assign pin_n[2 * p] = drive_n[2 * p] || !TRIP_N; // RL16 RL26
            assign pin_n[2 * p + 1] = drive_n[2 * p + 1] || !TRIP_N; // RL16 RL26
        end
    endgenerate

    assign PAIR0_HIGH_OUT = pin_n[0]; // RL1
    assign PAIR0_LOW_OUT = pin_n[1];
    assign PAIR1_HIGH_OUT = pin_n[2];
    assign PAIR1_LOW_OUT = pin_n[3];
    assign PAIR2_HIGH_OUT = pin_n[4];
    assign PAIR2_LOW_OUT = pin_n[5];

endmodule : tpg_three_phase_pwm

// file: inc/tpg_pkg.sv
// constants, register map and state codes of the three-phase pwm generator
// Operation
// RL1 - six drive outputs form three pairs, each a high side and low side.
// RL2 - software sets switching frequency by period and dead time by dead-time register.
// RL3 - three duty registers each set switching instants of one pair.
// RL4 - each of six outputs has an enable bit; disabled output stays off.
// RL5 - per-pair crossover bit swaps high and low waveforms between the pins.
// RL6 - gate chopping mixes a carrier into outputs; 8-bit field sets its frequency.
// RL7 - chopping enabled separately for high-side and low-side outputs.
// RL8 - single update mode takes new values once per period, giving symmetry.
// RL9 - double update mode also takes new values at the period midpoint.
// RL10 - one mode control bit picks single or double update.
// RL11 - sync pulse at every period start, plus midpoint in double update.
// RL12 - internal sync drives the sync pin with pulse of programmed width.
// RL13 - a control bit selects external sync taken from the sync pin.
// RL14 - a control bit resynchronises external sync to core clock before use.
// RL15 - external sync pulses last more than two core clock periods.
// RL16 - trip input low forces all six outputs high, combinationally.
// RL17 - status shows trip input level and which half period is running.
// RL18 - timing unit makes three complementary dead-time-adjusted centre-based pairs.
// RL19 - shutdown controller handles trip and resets the timing unit.
// RL20 - runs on core clock; interrupts on each sync pulse and each shutdown.
// RL21 - 16-bit period counts core clocks per half period; 0 and 1 unused.
// RL22 - 10-bit dead time; gap between pair edges is value times two clocks.
// RL23 - at each sync, timing and enable registers are latched into use.
// RL24 - status bit 0 is zero in first half, one in second half.
// RL25 - up/down counter; outputs switch at dead-time-adjusted duty thresholds.
// RL26 - order: timing, crossover, enable, chopping, then trip override wins.
package tpg_pkg;
    localparam int TPG_AW = 8;
    localparam logic [7:0] TPG_OFS_PERIOD = 8'h00;
    localparam logic [7:0] TPG_OFS_DEAD = 8'h04;
    localparam logic [7:0] TPG_OFS_SYNCW = 8'h08;
    localparam logic [7:0] TPG_OFS_DUTY0 = 8'h0C;
    localparam logic [7:0] TPG_OFS_DUTY1 = 8'h10;
    localparam logic [7:0] TPG_OFS_DUTY2 = 8'h14;
    localparam logic [7:0] TPG_OFS_OUTEN = 8'h18;
    localparam logic [7:0] TPG_OFS_CHOP = 8'h1C;
    localparam logic [7:0] TPG_OFS_MODE = 8'h20;
    localparam logic [7:0] TPG_OFS_STATUS = 8'h24;
    // output enable register: bits 5:0 enables (2p high, 2p+1 low), 8:6 crossover
    localparam int TPG_EN_LSB = 0;
    localparam int TPG_XOVER_LSB = 6;
    // chopping register
    localparam int TPG_CHOP_HI_BIT = 8;
    localparam int TPG_CHOP_LO_BIT = 9;
    // mode control register
    localparam int TPG_MODE_RUN_BIT = 0;
    localparam int TPG_MODE_EXT_BIT = 1;
    localparam int TPG_MODE_DBL_BIT = 2;
    localparam int TPG_MODE_RESYNC_BIT = 3;
    // status register
    localparam int TPG_STA_HALF_BIT = 0;
    localparam int TPG_STA_TRIP_BIT = 1;
    localparam logic [15:0] TPG_PERIOD_RST = 16'hFFFF;
    localparam logic [9:0] TPG_DEAD_RST = 10'h000;
    localparam logic [9:0] TPG_SYNCW_RST = 10'h001;
    localparam logic [15:0] TPG_DUTY_RST = 16'h0000;
    localparam logic [8:0] TPG_OUTEN_RST = 9'h000;
    localparam logic [9:0] TPG_CHOP_RST = 10'h000;
    localparam logic [3:0] TPG_MODE_RST = 4'h0;
    typedef enum logic [2:0] {
        TPG_IDLE = 3'b001,
        TPG_FIRST = 3'b010,
        TPG_SECOND = 3'b100
    } tpg_half_t;
endpackage : tpg_pkg

// file: test/tpg_sync_source.sv
// far-side model: external sync source on the shared sync pin
`timescale 1ns/1ps
module tpg_sync_source
(
    input wire logic clk,
    input wire logic fire,
    output logic drive
);
    int left = 0;
    // pulse held three cycles, above the two-clock minimum
    always_ff @(posedge clk)
    begin
        if (fire)
            left <= 3;
        else if (left > 0)
            left <= left - 1;
    end
    // pin is driven low whenever no pulse is held
    assign drive = (left > 0);
endmodule : tpg_sync_source

// file: test/tpg_three_phase_pwm_assertions.sv
// concurrent checks on the pins of the three-phase pwm generator
`timescale 1ns/1ps
module tpg_three_phase_pwm_assertions
    import tpg_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic TRIP_N,
    input wire logic SYNC_OUT,
    input wire logic PAIR0_HIGH_OUT,
    input wire logic PAIR0_LOW_OUT,
    input wire logic PAIR1_HIGH_OUT,
    input wire logic PAIR1_LOW_OUT,
    input wire logic PAIR2_HIGH_OUT,
    input wire logic PAIR2_LOW_OUT,
    input wire logic SYNC_IRQ,
    input wire logic TRIP_IRQ
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    wire logic [5:0] outs = {PAIR2_LOW_OUT, PAIR2_HIGH_OUT, PAIR1_LOW_OUT,
        PAIR1_HIGH_OUT, PAIR0_LOW_OUT, PAIR0_HIGH_OUT};
    a_trip_forces_off: assert property (!TRIP_N |-> &outs)
        else $error("outputs not off while trip low");
    a_pair_never_both: assert property ((outs[1:0] != 2'b00) && (outs[3:2] != 2'b00)
        && (outs[5:4] != 2'b00))
        else $error("both switches of a pair on");
    a_read_data_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside read cycle");
    a_sync_irq_pulse: assert property (SYNC_IRQ |=> !SYNC_IRQ)
        else $error("sync interrupt longer than a cycle");
    a_sync_out_cause: assert property ($rose(SYNC_OUT) |-> SYNC_IRQ)
        else $error("sync pulse without sync instant");
    a_trip_irq_fall: assert property ($fell(TRIP_N) |-> ##[0:2] TRIP_IRQ)
        else $error("no shutdown interrupt");
    a_trip_irq_pulse: assert property (TRIP_IRQ |=> !TRIP_IRQ)
        else $error("shutdown interrupt longer than a cycle");
    a_trip_stops_sync: assert property ((!TRIP_N) [*3] |-> !SYNC_IRQ)
        else $error("timing unit runs during trip");
    a_reset_outs_off: assert property ($past(RST) |-> &outs && !SYNC_IRQ)
        else $error("outputs on after reset");
endmodule : tpg_three_phase_pwm_assertions
bind tpg_three_phase_pwm tpg_three_phase_pwm_assertions u_chk (.CORE_CLK(CORE_CLK),
    .RST(RST), .RD(RD), .RDATA(RDATA), .TRIP_N(TRIP_N), .SYNC_OUT(SYNC_OUT),
    .PAIR0_HIGH_OUT(PAIR0_HIGH_OUT), .PAIR0_LOW_OUT(PAIR0_LOW_OUT),
    .PAIR1_HIGH_OUT(PAIR1_HIGH_OUT), .PAIR1_LOW_OUT(PAIR1_LOW_OUT),
    .PAIR2_HIGH_OUT(PAIR2_HIGH_OUT), .PAIR2_LOW_OUT(PAIR2_LOW_OUT),
    .SYNC_IRQ(SYNC_IRQ), .TRIP_IRQ(TRIP_IRQ));

// file: test/tpg_three_phase_pwm_tb.sv
// self-checking bench of the three-phase pwm generator
`timescale 1ns/1ps
module tpg_three_phase_pwm_tb
    import tpg_pkg::*;
    ;
    logic CORE_CLK, RST, WR, RD, TRIP_N, fire, drv;
    logic [7:0] ADDR;
    logic [31:0] WDATA, RDATA, v, s;
    logic SYNC_OUT, SYNC_OE, SYNC_IRQ, TRIP_IRQ;
    wire [5:0] outs;
    wire sync_line = SYNC_OE ? SYNC_OUT : drv;
    int failures = 0, n_tests = 0, cycles = 0, n_per = 20, dead, n, h, l0;
    logic [7:0] ofs[9] = '{TPG_OFS_PERIOD, TPG_OFS_DEAD, TPG_OFS_SYNCW, TPG_OFS_DUTY0,
        TPG_OFS_DUTY1, TPG_OFS_DUTY2, TPG_OFS_OUTEN, TPG_OFS_CHOP, TPG_OFS_MODE};
    logic [31:0] msk[9] = '{32'hFFFF, 32'h3FF, 32'h3FF, 32'hFFFF, 32'hFFFF, 32'hFFFF,
        32'h1FF, 32'h3FF, 32'hE};
    logic [31:0] rstv[9] = '{32'(TPG_PERIOD_RST), 32'(TPG_DEAD_RST), 32'(TPG_SYNCW_RST),
        32'(TPG_DUTY_RST), 32'(TPG_DUTY_RST), 32'(TPG_DUTY_RST), 32'(TPG_OUTEN_RST),
        32'(TPG_CHOP_RST), 32'(TPG_MODE_RST)};

    tpg_three_phase_pwm DUT (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .TRIP_N(TRIP_N), .SYNC_IN(sync_line),
        .SYNC_OUT(SYNC_OUT), .SYNC_OE(SYNC_OE), .PAIR0_HIGH_OUT(outs[0]),
        .PAIR0_LOW_OUT(outs[1]), .PAIR1_HIGH_OUT(outs[2]), .PAIR1_LOW_OUT(outs[3]),
        .PAIR2_HIGH_OUT(outs[4]), .PAIR2_LOW_OUT(outs[5]), .SYNC_IRQ(SYNC_IRQ),
        .TRIP_IRQ(TRIP_IRQ));
    tpg_sync_source u_src (.clk(CORE_CLK), .fire(fire), .drive(drv));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CORE_CLK);
        WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CORE_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CORE_CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask : rd

    // negedges until the next sync interrupt, bounded
    task automatic wait_sync(output int c);
        c = 0;
        do
        begin
            @(negedge CORE_CLK);
            c++;
        end
        while (SYNC_IRQ !== 1'b1 && c < 500);
        if (c >= 500)
            failures++;
    endtask : wait_sync

    // low cycles over one period against the on-time formulas; ch 1 high, 2 low chopped
    task automatic pattern(input int d0, input int d1, input int d2, input int en,
        input int xo, input int ch);
        int dv[3];
        int on[6];
        int ex;
        int c;
        dv = '{d0, d1, d2};
        on = '{default: 0};
        wr(TPG_OFS_DEAD, 32'(dead));
        for (int p = 0; p < 3; p++)
            wr(TPG_OFS_DUTY0 + 8'(4 * p), 32'(dv[p]));
        wr(TPG_OFS_OUTEN, 32'(en | (xo << 6)));
        wr(TPG_OFS_CHOP, (ch > 0) ? (32'h80 << ch) | 32'h1 : 32'h0);
        wait_sync(c);
        wait_sync(c);
        for (int i = 0; i < 2 * n_per; i++)
        begin
            @(negedge CORE_CLK);
            for (int j = 0; j < 6; j++)
                on[j] += int'(outs[j] === 1'b0);
        end
        for (int j = 0; j < 6; j++)
        begin
            ex = ((j % 2) ^ ((xo >> (j / 2)) & 1)) ? n_per - dv[j / 2] - dead : dv[j / 2] - dead;
            ex = ((en >> j) & 1) ? 2 * ((ex > 0) ? ex : 0) : 0;
            if (ch == 1 + (j % 2))
                check(32'(on[j] < ex), 32'h1);
            else
                check(32'(on[j]), 32'(ex));
        end
    endtask : pattern

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        CORE_CLK = 1'b0;
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end

    always @(posedge CORE_CLK)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            end_of_test();
        end
    end

    initial
    begin
        RST = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 8'h00;
        WDATA = 32'h0;
        TRIP_N = 1'b1;
        fire = 1'b0;
        void'($urandom(32'h292d));
        repeat (20) @(posedge CORE_CLK);
        RST <= 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            rd(ofs[i], v);
            check(v, rstv[i]);
            s = $urandom & msk[i];
            wr(ofs[i], s);
            rd(ofs[i], v);
            check(v, s);
        end
        wr(8'h28, $urandom);
        rd(8'h28, v);
        check(v, 32'h0);
        wr(TPG_OFS_PERIOD, 32'(n_per));
        wr(TPG_OFS_SYNCW, 32'h3);
        wr(TPG_OFS_MODE, 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            dead = $urandom_range(3);
            pattern($urandom_range(20), $urandom_range(20), $urandom_range(20),
                (k == 0) ? 63 : $urandom_range(63), (k == 0) ? 0 : $urandom_range(7), 0);
        end
        dead = 2;
        pattern(10, 10, 10, 63, 0, 1);
        pattern(10, 10, 10, 63, 0, 2);
        wait_sync(n);
        for (h = 0; SYNC_OUT === 1'b1 && h < 50; h++)
            @(negedge CORE_CLK);
        wait_sync(n);
        check(32'(h), 32'h3);
        check(32'(SYNC_OE), 32'h1);
        check(32'(n + h), 32'(2 * n_per));
        wr(TPG_OFS_MODE, 32'h5);
        wait_sync(n);
        wait_sync(n);
        wait_sync(n);
        check(32'(n), 32'(n_per));
        rd(TPG_OFS_STATUS, s);
        wait_sync(n);
        rd(TPG_OFS_STATUS, v);
        check(32'(s[0] ^ v[0]), 32'h1);
        check(32'(v[1]), 32'h1);
        @(posedge CORE_CLK);
        TRIP_N <= 1'b0;
        #1 check(32'(outs), 32'h3F);
        for (n = 0; TRIP_IRQ !== 1'b1 && n < 4; n++)
            @(negedge CORE_CLK);
        check(32'(TRIP_IRQ), 32'h1);
        rd(TPG_OFS_STATUS, v);
        check(32'(v[1]), 32'h0);
        @(posedge CORE_CLK);
        TRIP_N <= 1'b1;
        wait_sync(n);
        check(32'(n < 500), 32'h1);
        wr(TPG_OFS_MODE, 32'h3);
        repeat (60) @(posedge CORE_CLK);
        check(32'(SYNC_OE), 32'h0);
        fire <= 1'b1;
        @(posedge CORE_CLK);
        fire <= 1'b0;
        wait_sync(l0);
        wr(TPG_OFS_MODE, 32'hB);
        repeat (60) @(posedge CORE_CLK);
        fire <= 1'b1;
        @(posedge CORE_CLK);
        fire <= 1'b0;
        wait_sync(n);
        check(32'(n - l0), 32'h2);
        end_of_test();
    end
endmodule : tpg_three_phase_pwm_tb
